// file: vrc_regs.svh
// constants of the voltage code reference and power-good block
// assumes a 50 MHz ref_clk and steps of 6.25 mV for all voltage arithmetic
`ifndef VRC_REGS_SVH
`define VRC_REGS_SVH
`define VRC_OFF_VOUT_CODE 8'h21
`define VRC_OFF_CONFIG_A 8'hd2
`define VRC_OFF_CONFIG_B 8'hd3
`define VRC_OFF_SLEW 8'hd6
`define VRC_OFF_TRIM 8'hdb
`define VRC_OFF_CAL 8'hdc
`define VRC_OFF_GOOD_HIGH 8'he0
`define VRC_OFF_GOOD_LOW 8'he1
`define VRC_OFF_STATUS 8'hf0
`define VRC_RST_VOUT_CODE 8'h00
`define VRC_RST_CONFIG 8'h00
`define VRC_RST_SLEW 8'h02
`define VRC_RST_TRIM 8'h00
`define VRC_RST_CAL 8'h00
`define VRC_RST_GOOD_HIGH 8'h00
`define VRC_RST_GOOD_LOW 8'h00
`define VRC_SRC_BIT 3
`define VRC_SIGN_BIT 5
`define VRC_OFFSET_MAX_STEPS 31
`define VRC_CODE_TOP_STEPS 258
`define VRC_OFF_CODE_LOW_MAX 8'h01
`define VRC_OFF_CODE_HIGH_MIN 8'hfe
`define VRC_NOCPU_CODE 8'hff
`define VRC_HIGH_BASE_STEPS 48
`define VRC_LOW_BASE_STEPS 80
`define VRC_LIMIT_STEP_STEPS 8
`define VRC_CLAMP_RELEASE_STEPS 48
`define VRC_CLK_NS 20
`define VRC_STEP_UV 6250
`define VRC_IGNORE_NS 200
`define VRC_BLANK_US 100
`define VRC_OFF_CONFIRM_US 5
`define VRC_GOOD_DELAY_US 20
`endif

// file: vrc_pkg.sv
// types shared by the voltage code reference block
// assumes the constants header is included by the design files
package vrc_pkg;
	typedef enum logic [5:0] {
		ST_OFF = 6'b000001,
		ST_RAMP = 6'b000010,
		ST_DELAY = 6'b000100,
		ST_RUN = 6'b001000,
		ST_CONFIRM = 6'b010000,
		ST_SHUT = 6'b100000
	} vrc_state_e;
	typedef logic [7:0] vrc_byte_t;
endpackage : vrc_pkg

// file: vrc_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module vrc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else if (clkEn) begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign syncOut = stage2_ff;
endmodule : vrc_sync
`default_nettype wire

// file: vrc_top.sv
// voltage code reference, slew, blanking and power-good control
// assumes pins asynchronous, register port and sense value on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "vrc_regs.svh"
module vrc_top #(
	parameter int BLANK_CYC = (`VRC_BLANK_US * 1000 + `VRC_CLK_NS - 1) / `VRC_CLK_NS,
	parameter int GOOD_DELAY_CYC = (`VRC_GOOD_DELAY_US * 1000 + `VRC_CLK_NS - 1) / `VRC_CLK_NS
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [7:0] voltageCodePins,
	input wire logic enablePin,
	input wire logic loadStepUpPin,
	input wire logic loadReleasePin,
	input wire logic [9:0] outputSense,
	input wire logic regWrite,
	input wire logic regRead,
	input wire vrc_pkg::vrc_byte_t regAddr,
	input wire vrc_pkg::vrc_byte_t regWdata,
	output vrc_pkg::vrc_byte_t regRdata,
	output logic regRdValid,
	output logic [9:0] refLevel,
	output logic controllerRun,
	output logic phaseBoost,
	output logic releaseDetect,
	output logic overvoltClamp,
	input wire logic powerOkIn,
	output logic powerOkOut,
	output logic powerOkOeN
);
	import vrc_pkg::*;

	localparam int IGNORE_CYC = (`VRC_IGNORE_NS + `VRC_CLK_NS - 1) / `VRC_CLK_NS;
	localparam int CONFIRM_CYC = (`VRC_OFF_CONFIRM_US * 1000 + `VRC_CLK_NS - 1) / `VRC_CLK_NS;
	localparam int STEP_NS = `VRC_STEP_UV;

	logic [7:0] pinSync;
	logic [3:0] miscSync;
	logic enableSync;
	logic stepUpSync;
	logic releaseSync;
	logic powerOkPinSync;

	vrc_sync #(.WIDTH(8)) uPinSync (
		.ref_clk(ref_clk),
		.reset(reset),
		.clkEn(clkEn),
		.asyncIn(voltageCodePins),
		.syncOut(pinSync)
	);

	vrc_sync #(.WIDTH(4)) uMiscSync (
		.ref_clk(ref_clk),
		.reset(reset),
		.clkEn(clkEn),
		.asyncIn({powerOkIn, loadReleasePin, loadStepUpPin, enablePin}),
		.syncOut(miscSync)
	);

	assign enableSync = miscSync[0];
	assign stepUpSync = miscSync[1];
	assign releaseSync = miscSync[2];
	assign powerOkPinSync = miscSync[3];

	// register file
	vrc_byte_t voutCode_ff;
	vrc_byte_t configA_ff;
	vrc_byte_t configB_ff;
	vrc_byte_t slew_ff;
	vrc_byte_t trim_ff;
	vrc_byte_t cal_ff;
	vrc_byte_t goodHigh_ff;
	vrc_byte_t goodLow_ff;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			voutCode_ff <= `VRC_RST_VOUT_CODE;
			configA_ff <= `VRC_RST_CONFIG;
			configB_ff <= `VRC_RST_CONFIG;
			slew_ff <= `VRC_RST_SLEW;
			trim_ff <= `VRC_RST_TRIM;
			cal_ff <= `VRC_RST_CAL;
			goodHigh_ff <= `VRC_RST_GOOD_HIGH;
			goodLow_ff <= `VRC_RST_GOOD_LOW;
		end else if (clkEn && regWrite) begin
			case (regAddr)
				`VRC_OFF_VOUT_CODE: voutCode_ff <= regWdata;
				`VRC_OFF_CONFIG_A: configA_ff <= regWdata;
				`VRC_OFF_CONFIG_B: configB_ff <= regWdata;
				`VRC_OFF_SLEW: slew_ff <= regWdata;
				`VRC_OFF_TRIM: trim_ff <= regWdata;
				`VRC_OFF_CAL: cal_ff <= regWdata;
				`VRC_OFF_GOOD_HIGH: goodHigh_ff <= regWdata;
				`VRC_OFF_GOOD_LOW: goodLow_ff <= regWdata;
				default: ;
			endcase
		end
	end

	// pin code filter
	vrc_byte_t pinPrev_ff;
	vrc_byte_t pinLatched_ff;
	logic [3:0] ignoreCnt_ff;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pinPrev_ff <= 8'h00;
			pinLatched_ff <= `VRC_NOCPU_CODE;
			ignoreCnt_ff <= 4'h0;
		end else if (clkEn) begin
			pinPrev_ff <= pinSync;
			if (pinSync != pinPrev_ff) begin
				ignoreCnt_ff <= 4'(IGNORE_CYC);
			end else if (ignoreCnt_ff != 4'h0) begin
				ignoreCnt_ff <= ignoreCnt_ff - 4'h1;
				if (ignoreCnt_ff == 4'h1) begin
					pinLatched_ff <= pinSync;
				end
			end
		end
	end

	// code source and offset
	logic useProgrammed;
	vrc_byte_t effCode;
	logic offCode;
	logic noCpu;
	logic signed [6:0] trimVal;
	logic signed [6:0] calVal;
	logic signed [6:0] offSum;
	logic signed [6:0] offSat;
	logic signed [11:0] goalCalc;
	logic [9:0] codeGoal;

	assign useProgrammed = configA_ff[`VRC_SRC_BIT] && configB_ff[`VRC_SRC_BIT];
	assign effCode = useProgrammed ? voutCode_ff : pinLatched_ff;
	assign offCode = (effCode <= `VRC_OFF_CODE_LOW_MAX) || (effCode >= `VRC_OFF_CODE_HIGH_MIN);
	assign noCpu = (pinLatched_ff == `VRC_NOCPU_CODE) && !useProgrammed;

	assign trimVal = trim_ff[`VRC_SIGN_BIT] ? -$signed({2'b00, trim_ff[4:0]})
		: $signed({2'b00, trim_ff[4:0]});
	assign calVal = cal_ff[`VRC_SIGN_BIT] ? -$signed({2'b00, cal_ff[4:0]})
		: $signed({2'b00, cal_ff[4:0]});
	assign offSum = trimVal + calVal;

	always_comb begin
		offSat = offSum;
		if (offSum > 7'sd31) begin
			offSat = 7'(`VRC_OFFSET_MAX_STEPS);
		end else if (offSum < -7'sd31) begin
			offSat = -7'(`VRC_OFFSET_MAX_STEPS);
		end
	end

	always_comb begin
		goalCalc = 12'sd0;
		codeGoal = 10'h000;
		if (!offCode) begin
			goalCalc = 12'(`VRC_CODE_TOP_STEPS) - $signed({4'h0, effCode})
				+ 12'(offSat);
			if (goalCalc > 12'sd0) begin
				codeGoal = goalCalc[9:0];
			end
		end
	end

	// code change blanking
	vrc_byte_t effPrev_ff;
	logic [12:0] blankCnt_ff;
	logic blanking;
	logic codeChange;

	assign codeChange = effCode != effPrev_ff;
	assign blanking = blankCnt_ff != 13'h0000;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			effPrev_ff <= `VRC_NOCPU_CODE;
			blankCnt_ff <= 13'h0000;
		end else if (clkEn) begin
			effPrev_ff <= effCode;
			if (codeChange) begin
				blankCnt_ff <= 13'(BLANK_CYC);
			end else if (blanking) begin
				blankCnt_ff <= blankCnt_ff - 13'h0001;
			end
		end
	end

	// sequencing
	vrc_state_e state_ff;
	vrc_state_e nxt_state;
	logic [9:0] slewRef_ff;
	logic [15:0] seqCnt_ff;
	logic atGoal;

	assign atGoal = slewRef_ff == codeGoal;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF: begin
				if (!offCode) begin
					nxt_state = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (atGoal) begin
					nxt_state = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (seqCnt_ff == 16'h0000) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (offCode) begin
					nxt_state = ST_CONFIRM;
				end
			end
			ST_CONFIRM: begin
				if (!offCode) begin
					nxt_state = ST_RUN;
				end else if (seqCnt_ff == 16'h0000) begin
					nxt_state = ST_SHUT;
				end
			end
			ST_SHUT: begin
				if (!offCode) begin
					nxt_state = ST_RAMP;
				end
			end
			default: nxt_state = ST_OFF;
		endcase
		if (!enableSync) begin
			nxt_state = ST_OFF;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_ff <= ST_OFF;
		end else if (clkEn) begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			seqCnt_ff <= 16'h0000;
		end else if (clkEn) begin
			if (nxt_state != state_ff) begin
				if (nxt_state == ST_DELAY) begin
					seqCnt_ff <= 16'(GOOD_DELAY_CYC - 1);
				end else if (nxt_state == ST_CONFIRM) begin
					seqCnt_ff <= 16'(CONFIRM_CYC - 1);
				end else begin
					seqCnt_ff <= 16'h0000;
				end
			end else if (seqCnt_ff != 16'h0000) begin
				seqCnt_ff <= seqCnt_ff - 16'h0001;
			end
		end
	end

	// slew limiting
	logic [8:0] stepCnt_ff;
	logic [8:0] stepReload;
	logic [9:0] slewGoal;
	logic [4:0] rateVpm;

	// rate code to volts per ms
	assign rateVpm = {1'b0, slew_ff[2:0], 1'b1};
	assign stepReload = 9'((STEP_NS + int'(rateVpm) * `VRC_CLK_NS - 1)
		/ (int'(rateVpm) * `VRC_CLK_NS) - 1);
	assign slewGoal = (state_ff == ST_OFF || state_ff == ST_SHUT) ? 10'h000 : codeGoal;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			slewRef_ff <= 10'h000;
			stepCnt_ff <= 9'h000;
		end else if (clkEn) begin
			if (slewRef_ff == slewGoal) begin
				stepCnt_ff <= stepReload;
			end else if (stepCnt_ff != 9'h000) begin
				stepCnt_ff <= stepCnt_ff - 9'h001;
			end else begin
				stepCnt_ff <= stepReload;
				if (slewRef_ff < slewGoal) begin
					slewRef_ff <= slewRef_ff + 10'h001;
				end else begin
					slewRef_ff <= slewRef_ff - 10'h001;
				end
			end
		end
	end

	// window monitors
	logic [11:0] highSteps;
	logic [11:0] lowSteps;
	logic [11:0] upperLim;
	logic inWindow;
	logic overHigh;
	logic active;

	assign highSteps = 12'(`VRC_HIGH_BASE_STEPS)
		- 12'(`VRC_LIMIT_STEP_STEPS) * {10'h000, goodHigh_ff[1:0]};
	assign lowSteps = 12'(`VRC_LOW_BASE_STEPS)
		- 12'(`VRC_LIMIT_STEP_STEPS) * {9'h000, goodLow_ff[2:0]};
	assign upperLim = {2'b00, slewRef_ff} + highSteps;
	assign overHigh = {2'b00, outputSense} > upperLim;
	assign inWindow = !overHigh && ({2'b00, outputSense} + lowSteps >= {2'b00, slewRef_ff});
	assign active = state_ff == ST_RUN || state_ff == ST_CONFIRM;

	logic powerOk_ff;
	logic clamp_ff;
	logic boost_ff;
	logic release_ff;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			powerOk_ff <= 1'b0;
		end else if (clkEn) begin
			powerOk_ff <= active && enableSync && !noCpu && (inWindow || blanking);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			clamp_ff <= 1'b0;
		end else if (clkEn) begin
			if (state_ff != ST_OFF && !blanking && overHigh) begin
				clamp_ff <= 1'b1;
			end else if (outputSense < 10'(`VRC_CLAMP_RELEASE_STEPS)) begin
				clamp_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			boost_ff <= 1'b0;
			release_ff <= 1'b0;
		end else if (clkEn) begin
			boost_ff <= stepUpSync && active;
			release_ff <= releaseSync && state_ff != ST_OFF;
		end
	end

	// register read port
	vrc_byte_t rdMux;
	vrc_byte_t rdData_ff;
	logic rdValid_ff;

	always_comb begin
		case (regAddr)
			`VRC_OFF_VOUT_CODE: rdMux = voutCode_ff;
			`VRC_OFF_CONFIG_A: rdMux = configA_ff;
			`VRC_OFF_CONFIG_B: rdMux = configB_ff;
			`VRC_OFF_SLEW: rdMux = slew_ff;
			`VRC_OFF_TRIM: rdMux = trim_ff;
			`VRC_OFF_CAL: rdMux = cal_ff;
			`VRC_OFF_GOOD_HIGH: rdMux = goodHigh_ff;
			`VRC_OFF_GOOD_LOW: rdMux = goodLow_ff;
			`VRC_OFF_STATUS: rdMux = {1'b0, powerOkPinSync, clamp_ff, state_ff == ST_SHUT,
				blanking, useProgrammed, powerOk_ff, active};
			default: rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdData_ff <= 8'h00;
			rdValid_ff <= 1'b0;
		end else if (clkEn) begin
			rdValid_ff <= regRead;
			if (regRead) begin
				rdData_ff <= rdMux;
			end
		end
	end

	assign regRdata = rdData_ff;
	assign regRdValid = rdValid_ff;
	assign refLevel = slewRef_ff;
	assign controllerRun = state_ff != ST_OFF && state_ff != ST_SHUT;
	assign phaseBoost = boost_ff;
	assign releaseDetect = release_ff;
	assign overvoltClamp = clamp_ff;
	assign powerOkOut = 1'b0;
	assign powerOkOeN = powerOk_ff;
endmodule : vrc_top
`default_nettype wire

// file: vrc_top_assertions.sv
// concurrent checks on the ports of vrc_top
// assumes clkEn stays high and every port runs on ref_clk
`timescale 1ns/1ps
`default_nettype none
module vrc_checker #(
	parameter int GOOD_DELAY_CYC = 1000
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic enablePin,
	input wire logic loadStepUpPin,
	input wire logic loadReleasePin,
	input wire logic regRead,
	input wire logic regRdValid,
	input wire logic [9:0] refLevel,
	input wire logic controllerRun,
	input wire logic phaseBoost,
	input wire logic releaseDetect,
	input wire logic powerOkOeN
);
	int stableCnt_ff;
	logic [9:0] lastRef_ff;
	logic wasGood_ff;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// cycles the reference has stood still while running
	always_ff @(posedge ref_clk) begin
		lastRef_ff <= refLevel;
		stableCnt_ff <= (reset || !controllerRun || refLevel != lastRef_ff) ? 0 : stableCnt_ff + 1;
	end
	// power_ok already seen since the controller started
	always_ff @(posedge ref_clk) begin
		wasGood_ff <= !reset && controllerRun && (wasGood_ff || powerOkOeN);
	end
	sequence s_relHeld;
		(loadReleasePin && controllerRun)[*6];
	endsequence
	sequence s_stepIdle;
		(!loadStepUpPin)[*6];
	endsequence
	property p_rdAnswer;
		regRead && clkEn |=> regRdValid;
	endproperty
	a_rdAnswer: assert property (p_rdAnswer) else $error("read answer missing");
	property p_rdOnce;
		!(regRead && clkEn) |=> !regRdValid;
	endproperty
	a_rdOnce: assert property (p_rdOnce) else $error("read answer without request");
	property p_enableOff;
		(!enablePin)[*6] |-> !powerOkOeN;
	endproperty
	a_enableOff: assert property (p_enableOff) else $error("good while disabled");
	property p_goodState;
		powerOkOeN |-> $past(controllerRun);
	endproperty
	a_goodState: assert property (p_goodState) else $error("good while stopped");
	property p_goodDelay;
		$rose(powerOkOeN) && !wasGood_ff |-> stableCnt_ff >= GOOD_DELAY_CYC;
	endproperty
	a_goodDelay: assert property (p_goodDelay) else $error("good before delay");
	property p_slewStep;
		$changed(refLevel) |-> (refLevel == $past(refLevel) + 10'h001)
			|| (refLevel + 10'h001 == $past(refLevel));
	endproperty
	a_slewStep: assert property (p_slewStep) else $error("reference jumped");
	property p_slewHold;
		$changed(refLevel) |=> $stable(refLevel)[*8];
	endproperty
	a_slewHold: assert property (p_slewHold) else $error("reference slews too fast");
	property p_releaseDet;
		s_relHeld |-> releaseDetect;
	endproperty
	a_releaseDet: assert property (p_releaseDet) else $error("release not flagged");
	property p_boostIdle;
		s_stepIdle |-> !phaseBoost;
	endproperty
	a_boostIdle: assert property (p_boostIdle) else $error("boost without step");
endmodule : vrc_checker
bind vrc_top vrc_checker #(.GOOD_DELAY_CYC(GOOD_DELAY_CYC)) u_chk (
	.ref_clk(ref_clk),
	.reset(reset),
	.clkEn(clkEn),
	.enablePin(enablePin),
	.loadStepUpPin(loadStepUpPin),
	.loadReleasePin(loadReleasePin),
	.regRead(regRead),
	.regRdValid(regRdValid),
	.refLevel(refLevel),
	.controllerRun(controllerRun),
	.phaseBoost(phaseBoost),
	.releaseDetect(releaseDetect),
	.powerOkOeN(powerOkOeN)
);
`default_nettype wire

// file: vrc_partner.sv
// processor model driving the voltage code pins
// assumes codeReq changes just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module vrc_partner (
	input wire logic ref_clk,
	input wire logic [7:0] codeReq,
	output logic [7:0] voltageCodePins
);
	logic [7:0] held_ff = 8'hff;
	int skew_ff = 0;
	initial voltageCodePins = 8'hff;
	// low nibble first, high nibble later
	always @(posedge ref_clk) begin
		if (codeReq !== held_ff) begin
			held_ff <= codeReq;
			voltageCodePins <= {voltageCodePins[7:4], codeReq[3:0]};
			skew_ff <= 3;
		end else if (skew_ff == 1) begin
			voltageCodePins <= held_ff;
			skew_ff <= 0;
		end else if (skew_ff > 1) begin
			skew_ff <= skew_ff - 1;
		end
	end
endmodule : vrc_partner
`default_nettype wire

// file: test_vid_reference_and_power_good.sv
// self-checking bench for the voltage code reference block
// assumes shortened blanking and turn-on delay parameters
`timescale 1ns/1ps
`default_nettype none
`include "vrc_regs.svh"
module test_vid_reference_and_power_good;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic enablePin = 1'b0;
	logic loadStepUpPin = 1'b0;
	logic loadReleasePin = 1'b0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] codeReq = 8'hff;
	logic [9:0] outputSense = 10'h000;
	logic [9:0] senseOfs = 10'h000;
	logic [9:0] last;
	wire logic [7:0] codePins;
	wire logic [7:0] regRdata;
	wire logic [9:0] refLevel;
	wire logic regRdValid, controllerRun, phaseBoost, releaseDetect, overvoltClamp;
	wire logic powerOkOut, powerOkOeN;
	wire logic powerOkIn = powerOkOeN ? 1'b1 : powerOkOut;
	int mismatches = 0;
	int total_checks = 0;
	int n;
	logic [7:0] trimTab [4] = '{8'h08, 8'h21, 8'h1f, 8'h3f};
	logic [7:0] calTab [4] = '{8'h02, 8'h2e, 8'h1f, 8'h3f};
	int refTab [4] = '{140, 115, 161, 99};
	int slewTab [8] = '{313, 105, 63, 45, 35, 29, 25, 21};
	logic [1:0] hiTab [4] = '{2'h3, 2'h0, 2'h0, 2'h0};
	logic [2:0] loTab [4] = '{3'h0, 3'h0, 3'h7, 3'h0};
	logic [9:0] ofsTab [4] = '{10'h01e, 10'h028, 10'h3e2, 10'h3e2};
	logic [3:0] okTab = 4'b1010;
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) outputSense <= refLevel + senseOfs;
	vrc_partner cpu (.ref_clk(ref_clk), .codeReq(codeReq), .voltageCodePins(codePins));
	vrc_top #(.BLANK_CYC(20), .GOOD_DELAY_CYC(5)) uut (
		.ref_clk(ref_clk), .reset(reset), .clkEn(1'b1), .voltageCodePins(codePins),
		.enablePin(enablePin), .loadStepUpPin(loadStepUpPin),
		.loadReleasePin(loadReleasePin), .outputSense(outputSense),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .regRdValid(regRdValid), .refLevel(refLevel),
		.controllerRun(controllerRun), .phaseBoost(phaseBoost),
		.releaseDetect(releaseDetect), .overvoltClamp(overvoltClamp),
		.powerOkIn(powerOkIn), .powerOkOut(powerOkOut), .powerOkOeN(powerOkOeN)
	);
	task check(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task summarize;
		$display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		check({9'h000, regRdValid}, 10'h001);
		check({2'h0, regRdata}, {2'h0, exp});
	endtask : rd
	task waitRef(input logic [9:0] exp);
		n = 0;
		while (refLevel !== exp && n < 6000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check(refLevel, exp);
		if (n >= 6000) summarize();
	endtask : waitRef
	task waitMove;
		last = refLevel;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (refLevel === last && n < 2000);
		if (n >= 2000) check(refLevel, ~last);
		if (n >= 2000) summarize();
	endtask : waitMove
	task waitOk(input logic exp);
		n = 0;
		while (powerOkOeN !== exp && n < 6000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check({9'h000, powerOkOeN}, {9'h000, exp});
		if (n >= 6000) summarize();
	endtask : waitOk
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		rd(`VRC_OFF_SLEW, 8'h02);
		rd(`VRC_OFF_GOOD_HIGH, 8'h00);
		rd(`VRC_OFF_GOOD_LOW, 8'h00);
		rd(`VRC_OFF_CONFIG_A, 8'h00);
		rd(8'h55, 8'h00);
		wr(`VRC_OFF_SLEW, 8'h07);
		rd(`VRC_OFF_SLEW, 8'h07);
		@(posedge ref_clk);
		codeReq <= 8'h80;
		enablePin <= 1'b1;
		waitRef(10'd130);
		check({9'h000, powerOkOeN}, 10'h000);
		waitOk(1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(`VRC_OFF_TRIM, trimTab[i]);
			wr(`VRC_OFF_CAL, calTab[i]);
			waitRef(refTab[i][9:0]);
		end
		wr(`VRC_OFF_TRIM, 8'h00);
		wr(`VRC_OFF_CAL, 8'h00);
		waitRef(10'd130);
		wr(`VRC_OFF_VOUT_CODE, 8'ha0);
		wr(`VRC_OFF_CONFIG_A, 8'h08);
		repeat (40) @(posedge ref_clk);
		check(refLevel, 10'd130);
		wr(`VRC_OFF_CONFIG_B, 8'h08);
		waitRef(10'd98);
		wr(`VRC_OFF_VOUT_CODE, 8'h90);
		waitRef(10'd114);
		wr(`VRC_OFF_CONFIG_B, 8'h00);
		waitRef(10'd130);
		@(posedge ref_clk);
		codeReq <= 8'h7f;
		waitMove;
		check(refLevel, 10'd131);
		for (int i = 0; i < 8; i++) begin
			wr(`VRC_OFF_SLEW, i[7:0]);
			wr(`VRC_OFF_TRIM, i[0] ? 8'h00 : 8'h02);
			waitMove;
			waitMove;
			check(n[9:0], slewTab[i][9:0]);
		end
		@(posedge ref_clk);
		codeReq <= 8'h80;
		waitRef(10'd130);
		for (int i = 0; i < 4; i++) begin
			wr(`VRC_OFF_GOOD_HIGH, {6'h00, hiTab[i]});
			wr(`VRC_OFF_GOOD_LOW, {5'h00, loTab[i]});
			@(posedge ref_clk);
			senseOfs <= ofsTab[i];
			waitOk(okTab[i]);
		end
		check({9'h000, overvoltClamp}, 10'h001);
		wr(`VRC_OFF_GOOD_HIGH, 8'h03);
		wr(`VRC_OFF_VOUT_CODE, 8'h80);
		wr(`VRC_OFF_CONFIG_B, 8'h08);
		wr(`VRC_OFF_VOUT_CODE, 8'h7f);
		@(posedge ref_clk);
		senseOfs <= 10'h01e;
		rd(`VRC_OFF_STATUS, 8'h6f);
		repeat (5) @(posedge ref_clk);
		#1;
		check({9'h000, powerOkOeN}, 10'h001);
		waitOk(1'b0);
		check({9'h000, n >= 5}, 10'h001);
		wr(`VRC_OFF_GOOD_HIGH, 8'h00);
		wr(`VRC_OFF_CONFIG_B, 8'h00);
		@(posedge ref_clk);
		senseOfs <= 10'h3e2;
		waitRef(10'd130);
		waitOk(1'b1);
		for (int i = 1; i >= 0; i--) begin
			@(posedge ref_clk);
			loadReleasePin <= i[0];
			loadStepUpPin <= i[0];
			repeat (6) @(posedge ref_clk);
			#1;
			check({9'h000, releaseDetect}, {9'h000, i[0]});
			check({9'h000, phaseBoost}, {9'h000, i[0]});
		end
		@(posedge ref_clk);
		codeReq <= 8'h00;
		n = 0;
		while (controllerRun === 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check({9'h000, n >= 250 && n <= 300}, 10'h001);
		if (n >= 1000) summarize();
		@(posedge ref_clk);
		codeReq <= 8'h80;
		waitOk(1'b1);
		@(posedge ref_clk);
		codeReq <= 8'hff;
		waitOk(1'b0);
		check({9'h000, n < 60}, 10'h001);
		@(posedge ref_clk);
		codeReq <= 8'h80;
		waitOk(1'b1);
		@(posedge ref_clk);
		enablePin <= 1'b0;
		waitOk(1'b0);
		check({9'h000, controllerRun}, 10'h000);
		check({9'h000, powerOkIn}, 10'h000);
		summarize();
	end
endmodule : test_vid_reference_and_power_good
`default_nettype wire
